// File: hdl/dac_port_params.svh
// How it works
// - serial input shifts into a 24-bit register, msb first, one bit per clock
// - a frame holds read flag, five address bits, 12 data bits, six spare
// - chip select low opens a frame; falling serial clock edges sample data
// - chip select high: serial clock and input ignored, output not driven
// - chip select rising decodes the frame into the addressed register
// - fewer than 24 falling edges: frame dropped, registers untouched
// - more than 24 falling edges: only the last 24 bits count
// - initialization pin levels are caught once after power-on and kept
// - serial output works only while the output-disable bit is zero
// - sleep bit zero selects normal chaining, one selects bypass
// - normal mode: overflow bits leave on output, changed on rising edges
// - sleep mode: input passes straight to output, nothing is taken in
// - wake pin low clears the sleep bit
// - with cs wake enabled, a frame of at most one edge clears sleep
// - read frame selects a register; its value leaves during the next frame
// - load pin low updates all outputs once data sit in their registers, if it was high at power-on
// - frame layout: bit 23 read, 20..16 address, 15..4 data
// - hardware reset low blocks the port and floats the serial output
// - output update mode is fixed after power-on from the load pin level
// - spare and reserved bits ignore writes and read back zero
`ifndef DAC_PORT_PARAMS_SVH
`define DAC_PORT_PARAMS_SVH

`define FRAME_W 24
`define DATA_W 12
`define ADDR_W 5
`define REG_NUM 32
`define RNW_BIT 23
`define ADDR_HI 20
`define ADDR_LO 16
`define DATA_HI 15
`define DATA_LO 4
`define RB_PAD_HI 8'h00
`define RB_PAD_LO 4'h0
`define MIN_EDGES 24
`define WAKE_MAX_EDGES 1
`define ADDR_CFG 5'h00
`define ADDR_RSVD 5'h05
`define ADDR_MODE 5'h06
`define DAC_FIRST 5'h07
`define DAC_LAST 5'h0F
`define GAIN_SEL 2'h3
`define CFG_SDO_DIS_BIT 2
`define CFG_WAKE_EN_BIT 0
`define MODE_SLEEP_BIT 11
`define MASK_FULL 12'hFFF
`define CFG_MASK 12'hFDF
`define MODE_MASK 12'h800
`define CFG_RESET 12'h800
`define GAIN_RESET 12'h800
`define STRAP_WAIT 2'h2

`endif

// File: hdl/dac_port_pkg.sv
`include "dac_port_params.svh"
package dac_port_pkg;

    typedef struct packed {
        logic cs_n;
        logic hw_reset_n;
        logic wake_n;
        logic load_n;
        logic clear_n;
        logic reset_sel;
    } pins_t;

    typedef struct packed {
        logic load_n;
        logic clear_n;
        logic hw_reset_n;
        logic cs_n;
        logic reset_sel;
    } strap_t;

    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] data;
    } reg_write_t;

endpackage

// File: hdl/dac_serial_port.sv
`timescale 1ns/1ps
`include "dac_port_params.svh"

module link_shift
    import dac_port_pkg::*;
#(
    parameter int CNT_W = 10
) (
    input wire logic sclk_i,
    input wire logic link_rst_n_i,
    input wire logic cs_n_i,
    input wire logic hw_reset_n_i,
    input wire logic sdi_i,
    input wire logic sleep_i,
    input wire logic gen_i,
    input wire logic [`FRAME_W-1:0] preload_i,
    output logic [`FRAME_W-1:0] shift_o,
    output logic [CNT_W-1:0] cnt_o
);
    typedef struct packed {
        logic [`FRAME_W-1:0] shift;
        logic [CNT_W-1:0] cnt;
        logic gen;
    } shift_state_t;

    shift_state_t r, n;
    logic active;

    // cs and the core-side words are quasi-static while edges arrive
    assign active = !cs_n_i && hw_reset_n_i;

    always_comb begin
        n = r;
        if (active) begin
            n.cnt = r.cnt + 1'b1;
            n.gen = gen_i;
            if (!sleep_i) begin
                if (r.gen != gen_i) begin
                    n.shift = {preload_i[`FRAME_W-2:0], sdi_i};
                end else begin
                    n.shift = {r.shift[`FRAME_W-2:0], sdi_i};
                end
            end
        end
    end

    always_ff @(negedge sclk_i or negedge link_rst_n_i) begin
        if (!link_rst_n_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign shift_o = r.shift;
    assign cnt_o = r.cnt;

    sleep_hold_a: assert property (@(negedge sclk_i) disable iff (!link_rst_n_i)
        sleep_i |=> $stable(r.shift))
        else $error("shift register moved in sleep mode");
endmodule

module link_out
    import dac_port_pkg::*;
(
    input wire logic sclk_i,
    input wire logic link_rst_n_i,
    input wire logic cs_n_i,
    input wire logic hw_reset_n_i,
    input wire logic gen_i,
    input wire logic msb_i,
    output logic sdo_o,
    output logic fresh_o
);
    typedef struct packed {
        logic sdo;
        logic gen;
    } out_state_t;

    out_state_t r, n;

    always_comb begin
        n = r;
        if (!cs_n_i && hw_reset_n_i) begin
            n.sdo = msb_i;
            n.gen = gen_i;
        end
    end

    always_ff @(posedge sclk_i or negedge link_rst_n_i) begin
        if (!link_rst_n_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign sdo_o = r.sdo;
    assign fresh_o = (r.gen != gen_i);
endmodule

////////////////////////////////////////////////////////////////////////////////

module dac_serial_port
    import dac_port_pkg::*;
#(
    parameter int CNT_W = 10
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    input wire logic hw_reset_n_i,
    input wire logic wake_pin_n_i,
    input wire logic load_outputs_n_i,
    input wire logic clear_outputs_n_i,
    input wire logic reset_value_select_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    output logic wr_valid_o,
    output reg_write_t wr_o,
    output logic update_o,
    output logic sleep_o,
    output logic serial_out_disable_o,
    output logic cs_wake_enable_o,
    output logic strap_valid_o,
    output strap_t strap_o
);
    typedef struct packed {
        pins_t s1;
        pins_t s2;
        logic [`FRAME_W-1:0] sh1;
        logic [`FRAME_W-1:0] sh2;
        logic [CNT_W-1:0] c1;
        logic [CNT_W-1:0] c2;
        logic [CNT_W-1:0] base;
        logic act_d;
        logic [`REG_NUM-1:0][`DATA_W-1:0] regs;
        logic [`FRAME_W-1:0] rb;
        logic gen;
        logic link_rst_n;
        logic [1:0] strap_wait;
        logic strap_done;
        strap_t strap;
        logic load_d;
        logic update;
        logic wr_valid;
        reg_write_t wr;
    } core_state_t;

    core_state_t r, n;
    pins_t pins;
    logic [`FRAME_W-1:0] link_shift_w;
    logic [CNT_W-1:0] link_cnt_w;
    logic link_sdo_w;
    logic link_fresh_w;
    logic act;
    logic commit;
    logic sleep;
    logic [CNT_W-1:0] delta;
    logic f_rnw;
    logic [`ADDR_W-1:0] f_addr;
    logic [`DATA_W-1:0] f_data;

    function automatic logic [`DATA_W-1:0] field_mask(input logic [`ADDR_W-1:0] a);
        logic [`DATA_W-1:0] m;
        m = `MASK_FULL;
        if (a == `ADDR_CFG) begin
            m = `CFG_MASK;
        end else if (a == `ADDR_MODE) begin
            m = `MODE_MASK;
        end else if (a == `ADDR_RSVD) begin
            m = '0;
        end
        return m;
    endfunction

    function automatic logic [`DATA_W-1:0] reg_default(input logic [`ADDR_W-1:0] a);
        logic [`DATA_W-1:0] v;
        v = '0;
        if (a == `ADDR_CFG) begin
            v = `CFG_RESET;
        end else if (a[`ADDR_W-1:`ADDR_W-2] == `GAIN_SEL) begin
            v = `GAIN_RESET;
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // link side

    link_shift #(
        .CNT_W(CNT_W)
    ) u_shift (
        .sclk_i(sclk_i),
        .link_rst_n_i(r.link_rst_n),
        .cs_n_i(cs_n_i),
        .hw_reset_n_i(hw_reset_n_i),
        .sdi_i(sdi_i),
        .sleep_i(sleep),
        .gen_i(r.gen),
        .preload_i(r.rb),
        .shift_o(link_shift_w),
        .cnt_o(link_cnt_w)
    );

    link_out u_out (
        .sclk_i(sclk_i),
        .link_rst_n_i(r.link_rst_n),
        .cs_n_i(cs_n_i),
        .hw_reset_n_i(hw_reset_n_i),
        .gen_i(r.gen),
        .msb_i(link_shift_w[`FRAME_W-1]),
        .sdo_o(link_sdo_w),
        .fresh_o(link_fresh_w)
    );

    // the pin path stays combinational: bypass needs a few ns, not a clock
    always_comb begin
        if (sleep) begin
            sdo_o = sdi_i;
        end else if (link_fresh_w) begin
            sdo_o = r.rb[`FRAME_W-1];
        end else begin
            sdo_o = link_sdo_w;
        end
    end

    assign sdo_oe_o = !cs_n_i && hw_reset_n_i && !serial_out_disable_o;

    ////////////////////////////////////////////////////////////////////////////
    // core side

    assign pins = '{cs_n: cs_n_i, hw_reset_n: hw_reset_n_i, wake_n: wake_pin_n_i,
                    load_n: load_outputs_n_i, clear_n: clear_outputs_n_i,
                    reset_sel: reset_value_select_i};
    assign sleep = r.regs[`ADDR_MODE][`MODE_SLEEP_BIT];
    assign act = !r.s2.cs_n && r.s2.hw_reset_n;
    assign commit = r.act_d && !act && r.s2.hw_reset_n;
    assign delta = r.c2 - r.base;
    assign f_rnw = r.sh2[`RNW_BIT];
    assign f_addr = r.sh2[`ADDR_HI:`ADDR_LO];
    assign f_data = r.sh2[`DATA_HI:`DATA_LO];

    always_comb begin
        n = r;
        n.update = 1'b0;
        n.wr_valid = 1'b0;
        n.s1 = pins;
        n.s2 = r.s1;
        n.sh1 = link_shift_w;
        n.sh2 = r.sh1;
        n.c1 = link_cnt_w;
        n.c2 = r.c1;
        n.act_d = act;
        n.link_rst_n = 1'b1;
        n.load_d = r.s2.load_n;
        if (!r.strap_done) begin
            if (r.strap_wait == `STRAP_WAIT) begin
                n.strap_done = 1'b1;
                n.strap = '{load_n: r.s2.load_n, clear_n: r.s2.clear_n,
                            hw_reset_n: r.s2.hw_reset_n, cs_n: r.s2.cs_n,
                            reset_sel: r.s2.reset_sel};
            end else begin
                n.strap_wait = r.strap_wait + 1'b1;
            end
        end
        if (!r.s2.hw_reset_n) begin
            for (int i = 0; i < `REG_NUM; i++) begin
                n.regs[i] = reg_default(`ADDR_W'(i));
            end
            n.rb = '0;
        end else if (commit) begin
            n.base = r.c2;
            n.gen = ~r.gen;
            n.rb = '0;
            if (sleep) begin
                if (r.regs[`ADDR_CFG][`CFG_WAKE_EN_BIT]
                    && delta <= CNT_W'(`WAKE_MAX_EDGES)) begin
                    n.regs[`ADDR_MODE][`MODE_SLEEP_BIT] = 1'b0;
                end
            end else if (delta >= CNT_W'(`MIN_EDGES)) begin
                if (f_rnw) begin
                    n.rb = {`RB_PAD_HI, r.regs[f_addr] & field_mask(f_addr), `RB_PAD_LO};
                end else begin
                    n.regs[f_addr] = f_data & field_mask(f_addr);
                    n.wr_valid = 1'b1;
                    n.wr = '{addr: f_addr, data: f_data & field_mask(f_addr)};
                    if (!r.strap.load_n && f_addr >= `DAC_FIRST && f_addr <= `DAC_LAST) begin
                        n.update = 1'b1;
                    end
                end
            end
        end
        if (!r.s2.wake_n) begin
            n.regs[`ADDR_MODE][`MODE_SLEEP_BIT] = 1'b0;
        end
        if (r.strap_done && r.strap.load_n && r.load_d && !r.s2.load_n) begin
            n.update = 1'b1;
        end
        if (!rst_n_i) begin
            n = '0;
            for (int i = 0; i < `REG_NUM; i++) begin
                n.regs[i] = reg_default(`ADDR_W'(i));
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        r <= n;
    end

    assign wr_valid_o = r.wr_valid;
    assign wr_o = r.wr;
    assign update_o = r.update;
    assign sleep_o = sleep;
    assign serial_out_disable_o = r.regs[`ADDR_CFG][`CFG_SDO_DIS_BIT];
    assign cs_wake_enable_o = r.regs[`ADDR_CFG][`CFG_WAKE_EN_BIT];
    assign strap_valid_o = r.strap_done;
    assign strap_o = r.strap;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    short_frame_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        commit && !sleep && delta < CNT_W'(`MIN_EDGES) |=> !wr_valid_o)
        else $error("short frame reached a register");

    write_commit_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        commit && !sleep && delta >= CNT_W'(`MIN_EDGES) && !f_rnw
        |=> wr_valid_o && wr_o.addr == $past(f_addr))
        else $error("full write frame not committed");

    read_no_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        commit && f_rnw |=> !wr_valid_o)
        else $error("read frame wrote a register");

    rb_field_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        commit && !sleep && f_rnw && delta >= CNT_W'(`MIN_EDGES) && r.s2.hw_reset_n
        |=> r.rb[`DATA_HI:`DATA_LO] == $past(r.regs[f_addr] & field_mask(f_addr))
            && r.rb[`RNW_BIT:`DATA_HI+1] == '0 && r.rb[`DATA_LO-1:0] == '0)
        else $error("read-back word misplaced");

    wake_pin_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !r.s2.wake_n |=> !sleep_o)
        else $error("wake pin did not clear sleep");

    cs_wake_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        commit && sleep && cs_wake_enable_o && delta > CNT_W'(`WAKE_MAX_EDGES)
        && r.s1.wake_n && r.s2.wake_n |=> sleep_o)
        else $error("long frame woke the port");

    sleep_frame_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        commit && sleep |=> !wr_valid_o)
        else $error("frame accepted in sleep mode");

    spare_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        wr_valid_o && wr_o.addr == `ADDR_RSVD |-> wr_o.data == '0)
        else $error("reserved bits stored");

    hw_block_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !r.s2.hw_reset_n ##1 !r.s2.hw_reset_n |-> !wr_valid_o && (hw_reset_n_i || !sdo_oe_o))
        else $error("port active in hardware reset");

    strap_keep_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        strap_valid_o && $past(strap_valid_o) |-> $stable(strap_o))
        else $error("caught pin levels changed");

    sdo_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        serial_out_disable_o |-> !sdo_oe_o)
        else $error("serial output driven while disabled");
endmodule

// File: tb/spi_host_model.sv
`timescale 1ns/1ps

module spi_host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o,
    input wire logic sdo_i,
    input wire logic sdo_oe_i
);
    logic oe_seen;

    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
        oe_seen = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // exact edge count, chip select raised after the last edge
    // clock stands still high outside frames
    task automatic xfer(input logic [47:0] w, input int n, output logic [47:0] got);
        got = '0;
        oe_seen = 1'b0;
        #3.1 cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            sdi_o = w[n-1-i];
            #6;
            got[n-1-i] = sdo_i;
            oe_seen = oe_seen | (sdo_oe_i === 1'b1);
            sclk_o = 1'b0;
            #6 sclk_o = 1'b1;
        end
        #6 cs_n_o = 1'b1;
        // released data line must not hold its last level
        sdi_o = ~sdi_o;
        #40;
    endtask
endmodule

// File: tb/tb_dac_serial_port.sv
`timescale 1ns/1ps

module tb_dac_serial_port;
    import dac_port_pkg::*;

    logic core_clk, rst_n, hw_n, wake_n, load_n, clr_n, rsel;
    logic sclk, cs_n, sdi, sdo, oe, sdo_line, wr_valid, upd, sleep, dis, wake_en, strap_ok;
    reg_write_t wr;
    strap_t strap;
    logic [47:0] got;
    int n_fail = 0;
    int n_checks = 0;
    int n_wr = 0;
    int n_upd = 0;

    // pull-up on the serial output line while undriven
    assign sdo_line = (oe === 1'b1) ? sdo : 1'b1;

    dac_serial_port i_dac_serial_port (
        .core_clk_i(core_clk), .rst_n_i(rst_n), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
        .hw_reset_n_i(hw_n), .wake_pin_n_i(wake_n), .load_outputs_n_i(load_n),
        .clear_outputs_n_i(clr_n), .reset_value_select_i(rsel), .sdo_o(sdo),
        .sdo_oe_o(oe), .wr_valid_o(wr_valid), .wr_o(wr), .update_o(upd),
        .sleep_o(sleep), .serial_out_disable_o(dis), .cs_wake_enable_o(wake_en),
        .strap_valid_o(strap_ok), .strap_o(strap)
    );

    spi_host_model i_spi_host_model (
        .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo_line), .sdo_oe_i(oe)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (wr_valid === 1'b1) n_wr++;
        if (upd === 1'b1) n_upd++;
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] fw(logic rnw, logic [4:0] a, logic [11:0] d);
        // spare bits set to ones: they must not matter
        return {rnw, 2'b11, a, d, 4'hF};
    endfunction

    task automatic chk(input string s, input logic [47:0] e, input logic [47:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", s, e, g);
        end
    endtask

    task automatic wr_frame(input logic [47:0] w, input int n, input int c, input logic [16:0] e);
        int n0;
        n0 = n_wr;
        i_spi_host_model.xfer(w, n, got);
        repeat (10) @(posedge core_clk);
        #1;
        chk("commits", 48'(c), 48'(n_wr - n0));
        if (c == 1) chk("write", 48'(e), 48'(wr));
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        n_fail++;
        tally_and_finish;
    end

    initial begin
        rst_n <= 1'b0;
        hw_n <= 1'b1;
        wake_n <= 1'b1;
        load_n <= 1'b1;
        clr_n <= 1'b1;
        rsel <= 1'b0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        #1;
        chk("strap", 48'h3E, 48'({strap_ok, strap}));
        chk("cfg", 48'h0, 48'({sleep, dis, wake_en}));
        chk("idle oe", 48'h0, 48'(oe));
        wr_frame({24'h0, fw(0, 5'h08, 12'hABC)}, 24, 1, {5'h08, 12'hABC});
        wr_frame({24'h0, fw(0, 5'h09, 12'h123)}, 23, 0, '0);
        // two words: the first ripples out, the second is kept
        wr_frame({fw(0, 5'h0A, 12'h555), fw(0, 5'h08, 12'h5A5)}, 48, 1, {5'h08, 12'h5A5});
        chk("chain out", {24'h0, fw(0, 5'h0A, 12'h555)}, got);
        wr_frame({24'h0, fw(1, 5'h08, 12'h000)}, 24, 0, '0);
        // reserved place used as the follow-up frame
        wr_frame({24'h0, fw(0, 5'h05, 12'hFFF)}, 24, 1, {5'h05, 12'h000});
        chk("read back", {32'h0, 12'h5A5, 4'h0}, got);
        wr_frame({24'h0, fw(0, 5'h00, 12'h001)}, 24, 1, {5'h00, 12'h001});
        chk("wake enable", 48'h1, 48'(wake_en));
        wr_frame({24'h0, fw(0, 5'h06, 12'h800)}, 24, 1, {5'h06, 12'h800});
        chk("sleep", 48'h1, 48'(sleep));
        wr_frame({24'h0, fw(0, 5'h08, 12'h123)}, 24, 0, '0);
        chk("bypass", {24'h0, fw(0, 5'h08, 12'h123)}, got);
        wr_frame(48'h0, 1, 0, '0);
        chk("cs wake", 48'h0, 48'(sleep));
        wr_frame({24'h0, fw(0, 5'h06, 12'hFFF)}, 24, 1, {5'h06, 12'h800});
        wr_frame(48'h0, 2, 0, '0);
        chk("no wake", 48'h1, 48'(sleep));
        @(posedge core_clk) wake_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        wake_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        chk("pin wake", 48'h0, 48'(sleep));
        n_upd = 0;
        @(posedge core_clk) load_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        load_n <= 1'b1;
        #1;
        chk("update", 48'h1, 48'(n_upd));
        wr_frame({24'h0, fw(0, 5'h00, 12'h004)}, 24, 1, {5'h00, 12'h004});
        chk("disable", 48'h1, 48'(dis));
        wr_frame({24'h0, fw(0, 5'h00, 12'h000)}, 24, 1, {5'h00, 12'h000});
        chk("oe disabled", 48'h0, 48'(i_spi_host_model.oe_seen));
        @(posedge core_clk) hw_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        wr_frame({24'h0, fw(0, 5'h08, 12'h777)}, 24, 0, '0);
        chk("oe in reset", 48'h0, 48'(i_spi_host_model.oe_seen));
        @(posedge core_clk) hw_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        // second reset with the load pin tied low: straps pick asynchronous update
        rst_n <= 1'b0;
        load_n <= 1'b0;
        clr_n <= 1'b0;
        rsel <= 1'b1;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        #1;
        chk("async strap", 48'h27, 48'({strap_ok, strap}));
        n_upd = 0;
        wr_frame({24'h0, fw(0, 5'h0A, 12'h321)}, 24, 1, {5'h0A, 12'h321});
        chk("async update", 48'h1, 48'(n_upd));
        tally_and_finish;
    end
endmodule
